/* File: rtl/gpio_port_pkg.sv */
// Package for the general-purpose port block: register map, reset values,
// package variants and LED sink levels.
// Assumes a single AHB-Lite slave on a 20 MHz system clock.
package gpio_port_pkg;

    // -----------------------------------------------------------------
    // Sizes
    // -----------------------------------------------------------------
    localparam int PORT_COUNT = 4;
    localparam int MAX_PINS = 25;
    localparam logic [11:0] ADDR_MASK = 12'hFFC;

    // -----------------------------------------------------------------
    // Register offsets, per port n: base + n * PORT_STRIDE; global registers from 0x080
    // -----------------------------------------------------------------
    localparam logic [11:0] PORT_STRIDE = 12'h020;
    localparam logic [11:0] OFF_DATA_OUT = 12'h000;
    localparam logic [11:0] OFF_DATA_IN = 12'h004;
    localparam logic [11:0] OFF_DIR = 12'h008;
    localparam logic [11:0] OFF_ALT_EN = 12'h00C;
    localparam logic [11:0] OFF_OPEN_DRAIN = 12'h010;
    localparam logic [11:0] OFF_HIGH_DRIVE = 12'h014;
    localparam logic [11:0] OFF_PULL_UP = 12'h018;
    localparam logic [11:0] OFF_STOP_WAKE = 12'h01C;
    localparam logic [11:0] OFF_ALT_SELECT_FIRST = 12'h080;
    localparam logic [11:0] OFF_ALT_SELECT_SECOND = 12'h084;
    localparam logic [11:0] OFF_LED_DRIVER_ENABLE = 12'h088;
    localparam logic [11:0] OFF_LED_LEVEL_HIGH = 12'h08C;
    localparam logic [11:0] OFF_LED_LEVEL_LOW = 12'h090;
    localparam logic [11:0] OFF_SYS_CTRL = 12'h094;
    localparam logic [11:0] OFF_SYS_STATUS = 12'h098;

    // -----------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------
    localparam int SYS_CTRL_RESET_PIN_GPIO = 0;
    localparam int STATUS_DEBUG_EN = 0;
    localparam int STATUS_XTAL_EN = 1;
    localparam int STATUS_RESET_PIN_FN = 2;

    // -----------------------------------------------------------------
    // Reset values
    // -----------------------------------------------------------------
    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // -----------------------------------------------------------------
    // Package variants and implemented-pin masks
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        PKG_SMALL = 2'b00,
        PKG_MEDIUM = 2'b01,
        PKG_LARGE = 2'b10
    } pkg_variant_e;

    localparam logic [7:0] MASK_SMALL_A = 8'h3F;
    localparam logic [7:0] MASK_FULL = 8'hFF;
    localparam logic [7:0] MASK_LOW4 = 8'h0F;
    localparam logic [7:0] MASK_LOW6 = 8'h3F;
    localparam logic [7:0] MASK_PIN0 = 8'h01;

    // Sink level codes from {level_high, level_low}: 3, 7, 13, 20 mA.
    localparam logic [1:0] LED_3MA = 2'b00;
    localparam logic [1:0] LED_7MA = 2'b01;
    localparam logic [1:0] LED_13MA = 2'b10;
    localparam logic [1:0] LED_20MA = 2'b11;

    // Debug unlock pattern shifted in on port A pin 0 during reset.
    localparam logic [7:0] UNLOCK_PATTERN = 8'hA5;

endpackage

/* File: rtl/gpio_port_pin_control.sv */
// General-purpose port block: four 8-bit ports with per-pin configuration,
// alternate-function takeover, port C LED sink drive and shared pins.
// Assumes an AHB-Lite master with single word transfers and synchronous pins.

`timescale 1ns/1ns

module gpio_port_pin_control #(
    parameter gpio_port_pkg::pkg_variant_e VARIANT = gpio_port_pkg::PKG_LARGE
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    // AHB-Lite slave.
    input wire logic hsel_i,
    input wire logic [11:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Pins, flattened A[7:0], B[15:8], C[23:16], D[31:24].
    input wire logic [31:0] pin_in_i,
    output logic [31:0] pin_out_o,
    output logic [31:0] pin_oe_o,
    output logic [31:0] pull_up_o,
    output logic [31:0] high_drive_o,
    output logic [31:0] stop_wake_o,
    // Peripheral side of alternate functions.
    input wire logic [31:0] alt_out_i,
    input wire logic [31:0] alt_oe_i,
    output logic [31:0] alt_in_o,
    // Timer mode for port A pins 0 and 6: high selects complement output.
    input wire logic timer0_out_mode_i,
    input wire logic timer1_out_mode_i,
    // Crystal oscillator.
    input wire logic xtal_en_i,
    input wire logic xtal_out_i,
    output logic xtal_in_o,
    // Port C LED sink drive.
    output logic [7:0] led_sink_en_o,
    output logic [15:0] led_sink_level_o,
    // Shared reset pin.
    output logic reset_request_o,
    // Debug.
    output logic debug_en_o
);

    // -----------------------------------------------------------------
    // Implemented-pin masks per package
    // -----------------------------------------------------------------
    logic [31:0] impl_mask;

    // The smallest package has only port A[5:0]; others have all of A, B and C (B and C low nibbles on medium) plus D0.
    always_comb begin
        case (VARIANT)
            gpio_port_pkg::PKG_SMALL: begin
                impl_mask = {24'h000000, gpio_port_pkg::MASK_SMALL_A};
            end
            gpio_port_pkg::PKG_MEDIUM: begin
                impl_mask = {gpio_port_pkg::MASK_PIN0, gpio_port_pkg::MASK_LOW4,
                             gpio_port_pkg::MASK_LOW4, gpio_port_pkg::MASK_FULL};
            end
            default: begin
                impl_mask = {gpio_port_pkg::MASK_PIN0, gpio_port_pkg::MASK_FULL,
                             gpio_port_pkg::MASK_FULL, gpio_port_pkg::MASK_FULL};
            end
        endcase
    end

    wire small_pkg = (VARIANT == gpio_port_pkg::PKG_SMALL);
    // Reset shares port A pin 2 on the smallest package, port D pin 0 elsewhere.
    wire [4:0] reset_pin_idx = small_pkg ? 5'h02 : 5'h18;

    // -----------------------------------------------------------------
    // AHB-Lite address phase capture
    // -----------------------------------------------------------------
    logic wr_pend_q;
    logic [11:0] wr_addr_q;
    wire take = hsel_i & hready_i & htrans_i[1];

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
        end else if (clk_en_i) begin
            wr_pend_q <= take & hwrite_i;
            if (take) begin
                wr_addr_q <= haddr_i & gpio_port_pkg::ADDR_MASK;
            end
        end
    end

    // Zero wait states; every access answers OKAY.
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    // -----------------------------------------------------------------
    // Per-port configuration registers
    // -----------------------------------------------------------------
    localparam int PORT_COUNT_L = gpio_port_pkg::PORT_COUNT;
    logic [7:0] data_out_q [PORT_COUNT_L];
    logic [7:0] dir_q [PORT_COUNT_L];
    logic [7:0] alt_en_q [PORT_COUNT_L];
    logic [7:0] open_drain_q [PORT_COUNT_L];
    logic [7:0] high_drive_q [PORT_COUNT_L];
    logic [7:0] pull_up_q [PORT_COUNT_L];
    logic [7:0] stop_wake_q [PORT_COUNT_L];

    // Write decode shared by the port generate and the global registers.
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    genvar p;
    generate
        for (p = 0; p < PORT_COUNT_L; p++) begin : g_port
            localparam logic [11:0] BASE = 12'(p) * gpio_port_pkg::PORT_STRIDE;
            wire [7:0] m = impl_mask[8*p +: 8];
            wire [7:0] wd = hwdata_i[7:0] & m;
            // Only implemented bits store; the rest read as zero.
            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    data_out_q[p] <= gpio_port_pkg::RST_ZERO;
                    dir_q[p] <= gpio_port_pkg::RST_DIR;
                    alt_en_q[p] <= gpio_port_pkg::RST_ZERO;
                    open_drain_q[p] <= gpio_port_pkg::RST_ZERO;
                    high_drive_q[p] <= gpio_port_pkg::RST_ZERO;
                    pull_up_q[p] <= gpio_port_pkg::RST_ZERO;
                    stop_wake_q[p] <= gpio_port_pkg::RST_ZERO;
                end else if (clk_en_i && wr_pend_q) begin
                    if (hit(wr_addr_q, BASE + gpio_port_pkg::OFF_DATA_OUT)) begin
                        data_out_q[p] <= wd;
                    end
                    if (hit(wr_addr_q, BASE + gpio_port_pkg::OFF_DIR)) begin
                        dir_q[p] <= wd;
                    end
                    if (hit(wr_addr_q, BASE + gpio_port_pkg::OFF_ALT_EN)) begin
                        alt_en_q[p] <= wd;
                    end
                    if (hit(wr_addr_q, BASE + gpio_port_pkg::OFF_OPEN_DRAIN)) begin
                        open_drain_q[p] <= wd;
                    end
                    if (hit(wr_addr_q, BASE + gpio_port_pkg::OFF_HIGH_DRIVE)) begin
                        high_drive_q[p] <= wd;
                    end
                    if (hit(wr_addr_q, BASE + gpio_port_pkg::OFF_PULL_UP)) begin
                        pull_up_q[p] <= wd;
                    end
                    if (hit(wr_addr_q, BASE + gpio_port_pkg::OFF_STOP_WAKE)) begin
                        stop_wake_q[p] <= wd;
                    end
                end
            end
        end
    endgenerate

    // -----------------------------------------------------------------
    // Global registers: alternate sets, LED control, shared pin control
    // -----------------------------------------------------------------
    logic [7:0] alt_select_first_q;
    logic [7:0] alt_select_second_q;
    logic [7:0] led_driver_enable_q;
    logic [7:0] led_level_high_q;
    logic [7:0] led_level_low_q;
    logic reset_pin_gpio_q;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            alt_select_first_q <= gpio_port_pkg::RST_ZERO;
            alt_select_second_q <= gpio_port_pkg::RST_ZERO;
            led_driver_enable_q <= gpio_port_pkg::RST_ZERO;
            led_level_high_q <= gpio_port_pkg::RST_ZERO;
            led_level_low_q <= gpio_port_pkg::RST_ZERO;
            reset_pin_gpio_q <= 1'b0;
        end else if (clk_en_i && wr_pend_q) begin
            if (hit(wr_addr_q, gpio_port_pkg::OFF_ALT_SELECT_FIRST)) begin
                alt_select_first_q <= hwdata_i[7:0];
            end
            if (hit(wr_addr_q, gpio_port_pkg::OFF_ALT_SELECT_SECOND)) begin
                alt_select_second_q <= hwdata_i[7:0];
            end
            if (hit(wr_addr_q, gpio_port_pkg::OFF_LED_DRIVER_ENABLE)) begin
                led_driver_enable_q <= hwdata_i[7:0];
            end
            if (hit(wr_addr_q, gpio_port_pkg::OFF_LED_LEVEL_HIGH)) begin
                led_level_high_q <= hwdata_i[7:0];
            end
            if (hit(wr_addr_q, gpio_port_pkg::OFF_LED_LEVEL_LOW)) begin
                led_level_low_q <= hwdata_i[7:0];
            end
            if (hit(wr_addr_q, gpio_port_pkg::OFF_SYS_CTRL)) begin
                // The reset function stays until software hands the pin over.
                reset_pin_gpio_q <= hwdata_i[gpio_port_pkg::SYS_CTRL_RESET_PIN_GPIO];
            end
        end
    end

    // -----------------------------------------------------------------
    // Debug unlock watcher (smallest package only)
    // -----------------------------------------------------------------
    // The pattern is shifted in while reset is held, since reset clears
    // everything else; the shift register itself has no async reset so it
    // can sample during the reset sequence.
    logic [7:0] unlock_shift_q;
    logic debug_en_q;
    logic rst_seen_q;

    always_ff @(posedge clock_i) begin
        if (rst_i && clk_en_i) begin
            unlock_shift_q <= {unlock_shift_q[6:0], pin_in_i[0]};
        end
    end

    // Decision is taken at the first enabled edge after release and then held
    // until the next reset, so a missing pattern keeps debug off.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            debug_en_q <= 1'b0;
            rst_seen_q <= 1'b1;
        end else if (clk_en_i && rst_seen_q) begin
            rst_seen_q <= 1'b0;
            debug_en_q <= small_pkg && (unlock_shift_q == gpio_port_pkg::UNLOCK_PATTERN);
        end
    end
    assign debug_en_o = debug_en_q;

    // -----------------------------------------------------------------
    // Pin muxing
    // -----------------------------------------------------------------
    wire [31:0] data_out_f = {data_out_q[3], data_out_q[2], data_out_q[1], data_out_q[0]};
    wire [31:0] dir_f = {dir_q[3], dir_q[2], dir_q[1], dir_q[0]};
    wire [31:0] alt_f = {alt_en_q[3], alt_en_q[2], alt_en_q[1], alt_en_q[0]};
    wire [31:0] od_f = {open_drain_q[3], open_drain_q[2], open_drain_q[1], open_drain_q[0]};

    // Port C pins in alternate mode with first select set and second select clear are in LED mode.
    wire [7:0] led_mode = alt_en_q[2] & alt_select_first_q & ~alt_select_second_q;
    wire [7:0] led_on = led_mode & led_driver_enable_q & impl_mask[23:16];

    // Alternate-function pins follow the peripheral's enable, not the dir bit.
    wire [31:0] gp_oe = ~dir_f & ~(od_f & data_out_f);
    wire [31:0] sel_oe = (alt_f & alt_oe_i) | (~alt_f & gp_oe);
    wire [31:0] sel_out = (alt_f & alt_out_i) | (~alt_f & data_out_f);

    // Timer complement output vs timer input on port A pins 0 and 6.
    wire pa0_oe = alt_f[0] ? timer0_out_mode_i : gp_oe[0];
    wire pa6_oe = alt_f[6] ? timer1_out_mode_i : gp_oe[6];

    wire rst_fn = ~reset_pin_gpio_q;
    wire xtal_own = xtal_en_i;

    logic [31:0] oe_c;
    logic [31:0] out_c;

    // Overrides applied in priority: reset pin, debug, crystal, LED, normal.
    always_comb begin
        out_c = sel_out;
        oe_c = sel_oe;
        oe_c[0] = pa0_oe;
        oe_c[6] = pa6_oe;
        // Port D pin 0 in GPIO mode never receives, so it always drives.
        if (!small_pkg) begin
            oe_c[24] = 1'b1;
        end
        if (xtal_own) begin
            oe_c[0] = 1'b0;
            oe_c[1] = 1'b1;
            out_c[1] = xtal_out_i;
        end
        if (small_pkg && debug_en_q) begin
            oe_c[0] = 1'b0;
        end
        if (rst_fn) begin
            oe_c[reset_pin_idx] = 1'b0;
        end
        out_c[23:16] = out_c[23:16] & ~led_on;
        oe_c[23:16] = oe_c[23:16] | led_on;
    end

    // Crystal removal simply drops the override: the registers were untouched.
    assign pin_out_o = out_c & impl_mask;
    assign pin_oe_o = oe_c & impl_mask;
    assign pull_up_o = {pull_up_q[3], pull_up_q[2], pull_up_q[1], pull_up_q[0]};
    assign high_drive_o = {high_drive_q[3], high_drive_q[2], high_drive_q[1], high_drive_q[0]};
    assign stop_wake_o = {stop_wake_q[3], stop_wake_q[2], stop_wake_q[1], stop_wake_q[0]};
    assign alt_in_o = pin_in_i & alt_f & impl_mask;
    assign xtal_in_o = xtal_en_i & pin_in_i[0];
    assign led_sink_en_o = led_on;

    // Level per pin is {high bit, low bit}, a 2-bit code of four currents.
    genvar l;
    generate
        for (l = 0; l < 8; l++) begin : g_led
            assign led_sink_level_o[2*l +: 2] = {led_level_high_q[l], led_level_low_q[l]};
        end
    endgenerate

    // Low on the shared pin while it holds the reset function requests reset.
    assign reset_request_o = rst_fn & ~pin_in_i[reset_pin_idx];

    // -----------------------------------------------------------------
    // Read path
    // -----------------------------------------------------------------
    logic [31:0] rdata_q;
    logic [7:0] rd_c;
    wire [11:0] ra = haddr_i & gpio_port_pkg::ADDR_MASK;
    wire [1:0] rport = ra[6:5];
    wire [11:0] roff = ra & 12'h01C;
    wire in_ports = (ra[11:7] == 5'h00);

    always_comb begin
        rd_c = 8'h00;
        if (in_ports) begin
            case (roff)
                gpio_port_pkg::OFF_DATA_OUT: rd_c = data_out_q[rport];
                gpio_port_pkg::OFF_DATA_IN: rd_c = pin_in_i[8*rport +: 8] & impl_mask[8*rport +: 8];
                gpio_port_pkg::OFF_DIR: rd_c = dir_q[rport] & impl_mask[8*rport +: 8];
                gpio_port_pkg::OFF_ALT_EN: rd_c = alt_en_q[rport];
                gpio_port_pkg::OFF_OPEN_DRAIN: rd_c = open_drain_q[rport];
                gpio_port_pkg::OFF_HIGH_DRIVE: rd_c = high_drive_q[rport];
                gpio_port_pkg::OFF_PULL_UP: rd_c = pull_up_q[rport];
                gpio_port_pkg::OFF_STOP_WAKE: rd_c = stop_wake_q[rport];
                default: rd_c = 8'h00;
            endcase
        end else begin
            case (ra)
                gpio_port_pkg::OFF_ALT_SELECT_FIRST: rd_c = alt_select_first_q;
                gpio_port_pkg::OFF_ALT_SELECT_SECOND: rd_c = alt_select_second_q;
                gpio_port_pkg::OFF_LED_DRIVER_ENABLE: rd_c = led_driver_enable_q;
                gpio_port_pkg::OFF_LED_LEVEL_HIGH: rd_c = led_level_high_q;
                gpio_port_pkg::OFF_LED_LEVEL_LOW: rd_c = led_level_low_q;
                gpio_port_pkg::OFF_SYS_CTRL: rd_c = {7'h00, reset_pin_gpio_q};
                gpio_port_pkg::OFF_SYS_STATUS: rd_c = {5'h00, rst_fn, xtal_en_i, debug_en_q};
                default: rd_c = 8'h00;
            endcase
        end
    end

    // Read data is registered at the address phase, valid in the data phase.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 32'h00000000;
        end else if (clk_en_i && take && !hwrite_i) begin
            rdata_q <= {24'h000000, rd_c};
        end
    end
    assign hrdata_o = rdata_q;

endmodule

/* File: bench/gpio_port_checker_sva.sv */
// Checker for the port block: bus answer, crystal takeover, reset pin and
// configuration hold. Assumes the large package, reset function on port D pin 0,
// and a clock enable that stays high.
`timescale 1ns/1ns
module gpio_port_checker (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic [31:0] pin_in_i,
    input wire logic [31:0] pin_out_o,
    input wire logic [31:0] pin_oe_o,
    input wire logic [31:0] pull_up_o,
    input wire logic [31:0] high_drive_o,
    input wire logic xtal_en_i,
    input wire logic xtal_out_i,
    input wire logic xtal_in_o,
    input wire logic reset_request_o,
    input wire logic debug_en_o
);
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    logic take_w;
    logic rd_w;
    logic wr_q;
    // A taken read updates read data; a taken write lands one edge later.
    assign take_w = hsel_i & hreadyout_o & htrans_i[1];
    assign rd_w = take_w & ~hwrite_i;
    // Remembering the write lets the hold check know when a change is legal.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wr_q <= 1'h0;
        end else begin
            wr_q <= take_w & hwrite_i;
        end
    end
    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    ready_okay_a: assert property (@(posedge clock_i) disable iff (rst_i)
        hreadyout_o && !hresp_o) else $error("slave stalled or gave an error");
    rdata_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !$past(rd_w) |-> $stable(hrdata_o)) else $error("read data moved");
    cfg_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !$past(wr_q) |-> $stable({pull_up_o, high_drive_o})) else $error("config moved");
    xtal_in_a: assert property (@(posedge clock_i) disable iff (rst_i)
        xtal_en_i |-> xtal_in_o == pin_in_i[0]) else $error("crystal input lost");
    xtal_out_a: assert property (@(posedge clock_i) disable iff (rst_i)
        xtal_en_i |-> pin_oe_o[1] && !pin_oe_o[0] && pin_out_o[1] == xtal_out_i)
        else $error("crystal pins not taken over");
    unimpl_pins_a: assert property (@(posedge clock_i) disable iff (rst_i)
        pin_oe_o[31:25] == 7'h00 && pull_up_o[31:25] == 7'h00) else $error("absent pin on");
    debug_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !$past(rst_i) && !$past(rst_i, 2) |-> $stable(debug_en_o)) else $error("debug moved");
    rst_pin_a: assert property (@(posedge clock_i) disable iff (rst_i)
        $past(rst_i) && !pin_in_i[24] |-> reset_request_o) else $error("reset pin ignored");
endmodule

bind gpio_port_pin_control gpio_port_checker u_chk (.clock_i(clock_i), .rst_i(rst_i),
    .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .pin_in_i(pin_in_i),
    .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pull_up_o(pull_up_o),
    .high_drive_o(high_drive_o), .xtal_en_i(xtal_en_i), .xtal_out_i(xtal_out_i),
    .xtal_in_o(xtal_in_o), .reset_request_o(reset_request_o), .debug_en_o(debug_en_o));

/* File: bench/board_model.sv */
// Board circuitry on the port pins: a pull-up on every pin and a switch per pin.
// Assumes the bench closes a switch only where a scenario means to force a level.
`timescale 1ns/1ns
module board_model (
    input wire logic [31:0] pin_out_i,
    input wire logic [31:0] pin_oe_i,
    input wire logic [31:0] force_en_i,
    input wire logic [31:0] force_val_i,
    output logic [31:0] level_o
);
    // A driving pin wins; the reset pin is pulled low only on command.
    assign level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & force_en_i & force_val_i)
        | (~pin_oe_i & ~force_en_i);
endmodule

/* File: bench/tb_gpio_port_pin_control.sv */
// Testbench for the port block, one task per scenario.
// Assumes the large package and board pull-ups on every pin.
`timescale 1ns/1ns
module tb_gpio_port_pin_control;
    logic clk, rst, hsel, hwrite, xen, xout, t0m, t1m, rreq, dbg, hrdy, hresp, xin;
    logic [1:0] htrans;
    logic [11:0] haddr;
    logic [7:0] led_en;
    logic [15:0] led_lvl;
    logic [31:0] hwdata, hrdata, rd, alt_out, alt_oe, fen, fval, lvl, pout, poe, pup, hdr;
    logic [31:0] swk, ain;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    localparam logic [11:0] DIR = gpio_port_pkg::OFF_DIR;
    localparam logic [11:0] ALT = gpio_port_pkg::OFF_ALT_EN;
    localparam logic [11:0] OUT = gpio_port_pkg::OFF_DATA_OUT;
    localparam logic [11:0] PU = gpio_port_pkg::OFF_PULL_UP;

    // Clock enable and transfer size never vary in this bench.
    gpio_port_pin_control u_dut (.clock_i(clk), .rst_i(rst), .clk_en_i(1'h1),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
        .hreadyout_o(hrdy), .hresp_o(hresp), .pin_in_i(lvl), .pin_out_o(pout),
        .pin_oe_o(poe), .pull_up_o(pup), .high_drive_o(hdr), .stop_wake_o(swk),
        .alt_out_i(alt_out), .alt_oe_i(alt_oe), .alt_in_o(ain), .timer0_out_mode_i(t0m),
        .timer1_out_mode_i(t1m), .xtal_en_i(xen), .xtal_out_i(xout), .xtal_in_o(xin),
        .led_sink_en_o(led_en), .led_sink_level_o(led_lvl), .reset_request_o(rreq),
        .debug_en_o(dbg));
    board_model u_board (.pin_out_i(pout), .pin_oe_i(poe), .force_en_i(fen),
        .force_val_i(fval), .level_o(lvl));

    // Clock and a cycle ceiling far above the hundred or so cycles the run needs.
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            stop_test();
        end
    end

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic stop_test();
        if (n_fail == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [11:0] pa(input logic [1:0] n, input logic [11:0] off);
        return off + gpio_port_pkg::PORT_STRIDE * {10'h000, n};
    endfunction
    // One single-word transfer; read data is taken at the data-phase edge.
    task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (hrdy !== 1'h1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hrdy !== 1'h1) @(posedge clk);
        rd = hrdata;
        #1;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        ahb(a, 1'h0, 32'h0);
        chk(rd, exp);
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic s_reset();
        rdc(pa(2'h0, DIR), 32'hFF);
        rdc(pa(2'h3, DIR), 32'h01);
        rdc(pa(2'h1, ALT), 32'h00);
        ahb(12'h0FC, 1'h1, 32'hFF);
        rdc(12'h0FC, 32'h0);
        @(posedge clk);
        fen <= 32'h01000000;
        #1;
        chk({30'h0, rreq, dbg}, 32'h2);
        @(posedge clk);
        fen <= 32'h0;
    endtask
    task automatic s_cfg();
        ahb(pa(2'h1, PU), 1'h1, 32'hFFFFFF5A);
        ahb(pa(2'h1, gpio_port_pkg::OFF_HIGH_DRIVE), 1'h1, 32'hA5);
        ahb(pa(2'h1, gpio_port_pkg::OFF_STOP_WAKE), 1'h1, 32'h3C);
        ahb(pa(2'h3, PU), 1'h1, 32'hFF);
        chk({pup[31:24], hdr[15:8], swk[15:8], pup[15:8]}, 32'h01A53C5A);
        rdc(pa(2'h1, PU), 32'h5A);
        ahb(pa(2'h2, DIR), 1'h1, 32'h00);
        ahb(pa(2'h2, OUT), 1'h1, 32'h3C);
        chk({poe[23:16], pout[23:16], 16'h0}, 32'hFF3C0000);
        ahb(pa(2'h2, gpio_port_pkg::OFF_OPEN_DRAIN), 1'h1, 32'hFF);
        chk({24'h0, poe[23:16]}, 32'hC3);
        rdc(pa(2'h2, gpio_port_pkg::OFF_DATA_IN), 32'h3C);
    endtask
    task automatic s_alt();
        @(posedge clk);
        alt_oe <= 32'h0000F041;
        alt_out <= 32'h0000A000;
        ahb(pa(2'h1, ALT), 1'h1, 32'hFF);
        chk({poe[15:8], pout[15:12], 4'h0, ain[15:8], 8'h0}, 32'hF0A0AF00);
        ahb(pa(2'h0, ALT), 1'h1, 32'h41);
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            t0m <= m[0];
            t1m <= !m[0];
            #1;
            chk({30'h0, poe[6], poe[0]}, {30'h0, !m[0], m[0]});
        end
    endtask
    task automatic s_led();
        ahb(pa(2'h2, ALT), 1'h1, 32'hFF);
        ahb(gpio_port_pkg::OFF_ALT_SELECT_FIRST, 1'h1, 32'hFF);
        ahb(gpio_port_pkg::OFF_LED_DRIVER_ENABLE, 1'h1, 32'h0F);
        ahb(gpio_port_pkg::OFF_LED_LEVEL_HIGH, 1'h1, 32'hFF);
        ahb(gpio_port_pkg::OFF_LED_LEVEL_LOW, 1'h1, 32'hFF);
        chk({poe[23:16], led_en, led_lvl}, 32'h0F0FFFFF);
        ahb(gpio_port_pkg::OFF_ALT_SELECT_SECOND, 1'h1, 32'hFF);
        chk({24'h0, led_en}, 32'h0);
    endtask
    task automatic s_xtal();
        ahb(pa(2'h0, ALT), 1'h1, 32'h00);
        ahb(pa(2'h0, DIR), 1'h1, 32'h00);
        ahb(pa(2'h0, OUT), 1'h1, 32'h01);
        @(posedge clk);
        xen <= 1'h1;
        xout <= 1'h1;
        fen <= 32'h1;
        #1;
        chk({28'h0, poe[1:0], pout[1], xin}, 32'hA);
        @(posedge clk);
        xen <= 1'h0;
        fen <= 32'h0;
        #1;
        chk({28'h0, poe[1:0], pout[1:0]}, 32'hD);
    endtask
    task automatic s_rpin();
        ahb(gpio_port_pkg::OFF_SYS_CTRL, 1'h1, 32'h1);
        rdc(gpio_port_pkg::OFF_SYS_STATUS, 32'h0);
        @(posedge clk);
        fen <= 32'h01000000;
        #1;
        chk({30'h0, poe[24], rreq}, 32'h2);
        @(posedge clk);
        rst <= 1'h1;
        #1;
        chk({31'h0, rreq}, 32'h1);
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        fen <= 32'h0;
        rdc(gpio_port_pkg::OFF_SYS_STATUS, 32'h4);
    endtask

    // Main sequence: reset for four cycles, then every scenario in turn.
    initial begin
        {rst, hsel, hwrite, xen, xout, t0m, t1m} = 7'h40;
        htrans = 2'h0;
        haddr = 12'h0;
        {hwdata, alt_out, alt_oe, fen, fval} = 160'h0;
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        s_reset();
        s_cfg();
        s_alt();
        s_led();
        s_xtal();
        s_rpin();
        stop_test();
    end
endmodule
